// file: pkg/sbc_pkg.sv
// sbc_pkg: shared constants and carrier types of the channel-zero serial bus block
package sbc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 16; // register address width
    localparam logic [15:0] OFF_SERIAL_MODE_CONTROL = 16'hff60; // mode, enable, compare flag
    localparam logic [15:0] OFF_BUS_SIGNAL_CONTROL = 16'hff61; // triggers and detect flags
    localparam logic [15:0] OFF_INTERRUPT_TIMING = 16'hff62; // interrupt timing select
    localparam logic [15:0] OFF_SERIAL_SHIFT = 16'hff63; // shift register
    localparam logic [15:0] OFF_SLAVE_ADDRESS = 16'hff64; // slave address register

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_SERIAL_MODE_CONTROL = 8'h00;
    localparam logic [7:0] RST_BUS_SIGNAL_CONTROL = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_TIMING = 8'h00;
    localparam logic [7:0] RST_SERIAL_SHIFT = 8'h00;
    localparam logic [7:0] RST_SLAVE_ADDRESS = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int POS_CLOCK_SELECT_LO = 0; // serial_mode_control
    localparam int POS_CLOCK_SELECT_HI = 1;
    localparam int POS_MODE_SELECT_LO = 2;
    localparam int POS_MODE_SELECT_MID = 3;
    localparam int POS_MODE_SELECT_HI = 4;
    localparam int POS_WAKE_UP_CONTROL = 5;
    localparam int POS_ADDRESS_COMPARE = 6;
    localparam int POS_CHANNEL_ENABLE = 7;
    localparam int POS_RELEASE_TRIGGER = 0; // bus_signal_control
    localparam int POS_COMMAND_TRIGGER = 1;
    localparam int POS_RELEASE_DETECT = 2;
    localparam int POS_COMMAND_DETECT = 3;
    localparam int POS_ACK_TRIGGER = 4;
    localparam int POS_ACK_ENABLE = 5;
    localparam int POS_ACK_DETECT = 6;
    localparam int POS_BUSY_ENABLE = 7;
    localparam int POS_RELEASE_IRQ = 5; // interrupt_timing_select
    localparam int POS_CLOCK_LEVEL = 6;

    // ****************************************
    // transfer shape
    // ****************************************
    localparam logic [3:0] BITS_PER_BYTE = 4'h8; // data clocks per byte
    localparam logic [3:0] CLOCKS_BUS_MODE = 4'h9; // data clocks plus acknowledge clock

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic serial_clock_pin; // clock line level
        logic data_bus_pin_b; // data line b level
        logic data_bus_pin_a; // data line a level
    } sbc_pin_in_type;

    typedef struct packed {
        logic serial_clock_o; // clock drive value
        logic serial_clock_oe_n; // low while clock is driven
        logic data_a_o; // data line a drive value
        logic data_a_oe_n; // low while line a is driven
        logic data_b_o; // data line b drive value
        logic data_b_oe_n; // low while line b is driven
    } sbc_pin_out_type;

    typedef enum {SBC_IDLE, SBC_WAIT_READY, SBC_SHIFT} sbc_state_type;

endpackage

// file: hdl/sbc_channel.sv
// sbc_channel: channel-zero serial bus engine with its register file
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RQ1 - shift register advances on falling clock edges; the code shifts it on rising edges and loads the output latch on falling edges
// RQ2 - output latch drives selected line, msb first
// RQ3 - rising clock edge captures selected line level
// RQ4 - start needs enable and clock idle
// RQ5 - writes while disabled never start transfer
// RQ6 - software loads all ones before receiving
// RQ7 - wake-up set keeps data output released
// RQ8 - busy-time write waits for line high
// RQ9 - eight bits done: stop, raise interrupt
// RQ10 - software releases bus before first byte
// RQ11 - master polls data line for ready
// RQ12 - busy persists until next falling edge
// RQ13 - software clears busy before setting wake-up
// RQ14 - address after release compared with slave address
// RQ15 - reset zeroes mode, control, timing registers
// RQ16 - clock select: pin, timer two, timer select
// RQ17 - mode select: three-wire, bus, two-wire pin
// RQ18 - wake-up gates interrupt to address match
// RQ19 - software keeps wake-up zero in two-wire
// RQ20 - compare flag: address equals shift, zero disabled
// RQ21 - release trigger sets latch, self clears
// RQ22 - clock level bit reads zero when disabled
// RQ23 - command trigger clears latch, self clears
// RQ24 - data rise with clock high marks release
// RQ25 - wake-up zero: interrupt at ninth rising edge
module sbc_channel (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [sbc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // internal clock sources, same clock domain
    input wire logic timer_two_output,
    input wire logic timer_clock_select,
    // bus pins
    input wire sbc_pkg::sbc_pin_in_type pins_in,
    output sbc_pkg::sbc_pin_out_type pins_out,
    // interrupt request pulse
    output logic channel_interrupt
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] sync1_q; // first stage, read only by second stage
    logic [2:0] sync2_q; // safe levels
    // one synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                end else begin
                    sync1_q[gi] <= pins_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // registers and state
    // ****************************************
    logic channel_enable_bit_q; // channel enable
    logic wake_up_control_q; // wake-up gating
    logic [2:0] mode_select_q; // hi, mid, lo
    logic [1:0] clock_select_q; // hi, lo
    logic busy_enable_q; // busy after acknowledge
    logic ack_enable_q; // acknowledge enable, stored only
    logic release_irq_q; // interrupt on release detect
    logic [7:0] serial_shift_reg_q; // shift register
    logic [7:0] slave_address_reg_q; // slave address
    logic serial_output_latch_q; // bit driven on data line
    logic release_detect_flag_q;
    logic command_detect_flag_q;
    logic ack_detect_q;
    logic ack_drive_q; // acknowledge low drive
    logic busy_drive_q; // busy low drive
    logic after_last_q; // waiting for falling edge after the byte
    logic [3:0] clock_count_q; // rising edges seen in this byte
    logic sck_level_q; // internally generated clock level
    logic sck_prev_q; // previous clock level for edges
    logic data_prev_q; // previous data level for edges
    sbc_pkg::sbc_state_type state_q;

    // ****************************************
    // decode of modes and strobes
    // ****************************************
    logic bus_mode; // addressed bus mode
    logic two_wire_mode; // plain two-wire mode
    logic use_pin_a; // which data line is the open-drain line
    logic internal_clk; // device makes the clock
    logic clk_tick; // half period tick of internal clock
    logic sck_now, data_now, sck_fall, sck_rise;
    logic wr_mode, wr_bus, wr_timing, wr_shift, wr_slave; // write decodes
    logic shift_req; // accepted write to the shift register
    logic byte_done; // last clock of the byte has risen
    logic [3:0] clocks_needed;

    assign bus_mode = mode_select_q == 3'b100 || mode_select_q == 3'b101; // RQ17
    assign two_wire_mode = mode_select_q[2] && mode_select_q[1];           // RQ17
    // lowest mode bit picks the open-drain line
    assign use_pin_a = mode_select_q[0]; // RQ17
    // upper clock select bit low means clock comes from the pin
    assign internal_clk = clock_select_q[1]; // RQ16
    assign clk_tick = clock_select_q[0] ? timer_clock_select : timer_two_output; // RQ16
    assign sck_now = internal_clk ? sck_level_q : sync2_q[2];
    assign data_now = use_pin_a ? sync2_q[0] : sync2_q[1];
    assign sck_fall = sck_prev_q && !sck_now;
    assign sck_rise = !sck_prev_q && sck_now;
    assign wr_mode = reg_write && reg_addr == sbc_pkg::OFF_SERIAL_MODE_CONTROL;
    assign wr_bus = reg_write && reg_addr == sbc_pkg::OFF_BUS_SIGNAL_CONTROL;
    assign wr_timing = reg_write && reg_addr == sbc_pkg::OFF_INTERRUPT_TIMING;
    assign wr_shift = reg_write && reg_addr == sbc_pkg::OFF_SERIAL_SHIFT;
    assign wr_slave = reg_write && reg_addr == sbc_pkg::OFF_SLAVE_ADDRESS;
    // writes while off or mid-byte are dropped
    assign shift_req = wr_shift && channel_enable_bit_q && state_q == sbc_pkg::SBC_IDLE
        && (bus_mode || two_wire_mode); // RQ4 RQ5
    assign clocks_needed = bus_mode ? sbc_pkg::CLOCKS_BUS_MODE : sbc_pkg::BITS_PER_BYTE;
    assign byte_done = state_q == sbc_pkg::SBC_SHIFT && sck_rise
        && clock_count_q == clocks_needed - 4'h1;

    // ****************************************
    // mode and control registers
    // ****************************************
    // all software fields start at zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin // RQ15
            channel_enable_bit_q <= sbc_pkg::RST_SERIAL_MODE_CONTROL[sbc_pkg::POS_CHANNEL_ENABLE];
            wake_up_control_q <= sbc_pkg::RST_SERIAL_MODE_CONTROL[sbc_pkg::POS_WAKE_UP_CONTROL];
            mode_select_q <= sbc_pkg::RST_SERIAL_MODE_CONTROL[4:2];
            clock_select_q <= sbc_pkg::RST_SERIAL_MODE_CONTROL[1:0];
            busy_enable_q <= sbc_pkg::RST_BUS_SIGNAL_CONTROL[sbc_pkg::POS_BUSY_ENABLE];
            ack_enable_q <= sbc_pkg::RST_BUS_SIGNAL_CONTROL[sbc_pkg::POS_ACK_ENABLE];
            release_irq_q <= sbc_pkg::RST_INTERRUPT_TIMING[sbc_pkg::POS_RELEASE_IRQ];
            slave_address_reg_q <= sbc_pkg::RST_SLAVE_ADDRESS;
        end else begin
            if (wr_mode) begin
                channel_enable_bit_q <= reg_wdata[sbc_pkg::POS_CHANNEL_ENABLE];
                wake_up_control_q <= reg_wdata[sbc_pkg::POS_WAKE_UP_CONTROL];
                mode_select_q <= reg_wdata[sbc_pkg::POS_MODE_SELECT_HI:sbc_pkg::POS_MODE_SELECT_LO];
                clock_select_q <= reg_wdata[sbc_pkg::POS_CLOCK_SELECT_HI:sbc_pkg::POS_CLOCK_SELECT_LO];
            end
            if (wr_bus) begin
                busy_enable_q <= reg_wdata[sbc_pkg::POS_BUSY_ENABLE];
                ack_enable_q <= reg_wdata[sbc_pkg::POS_ACK_ENABLE];
            end
            if (wr_timing) begin
                release_irq_q <= reg_wdata[sbc_pkg::POS_RELEASE_IRQ];
            end
            if (wr_slave) begin
                slave_address_reg_q <= reg_wdata;
            end
        end
    end
    // ****************************************
    // transfer sequencer
    // ****************************************
    // waits for ready, then counts rising edges of the byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= sbc_pkg::SBC_IDLE;
            clock_count_q <= 4'h0;
        end else if (!channel_enable_bit_q) begin
            state_q <= sbc_pkg::SBC_IDLE;
            clock_count_q <= 4'h0;
        end else begin
            unique case (state_q)
                sbc_pkg::SBC_IDLE: begin
                    if (shift_req) begin // RQ4
                        state_q <= sbc_pkg::SBC_WAIT_READY;
                    end
                end
                sbc_pkg::SBC_WAIT_READY: begin
                    // data kept; a slave holding the line low delays the start
                    if (!bus_mode || (data_now && !busy_drive_q)) begin // RQ8
                        state_q <= sbc_pkg::SBC_SHIFT;
                    end
                end
                sbc_pkg::SBC_SHIFT: begin
                    if (byte_done) begin // RQ9
                        state_q <= sbc_pkg::SBC_IDLE;
                        clock_count_q <= 4'h0;
                    end else if (sck_rise) begin
                        clock_count_q <= clock_count_q + 4'h1;
                    end
                end
            endcase
        end
    end
    // ****************************************
    // internal clock generator
    // ****************************************
    // toggles on each tick during a byte, parks high otherwise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_level_q <= 1'b1;
        end else if (state_q != sbc_pkg::SBC_SHIFT || byte_done) begin
            sck_level_q <= 1'b1;
        end else if (clk_tick) begin
            sck_level_q <= !sck_level_q;
        end
    end
    // edge history of clock and data lines
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_prev_q <= 1'b1;
            data_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_now;
            data_prev_q <= data_now;
        end
    end
    // ****************************************
    // shift register
    // ****************************************
    // loaded by software, samples the line on each of the first eight clock rising edges
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            serial_shift_reg_q <= sbc_pkg::RST_SERIAL_SHIFT;
        end else if (shift_req) begin
            serial_shift_reg_q <= reg_wdata;
        end else if (state_q == sbc_pkg::SBC_SHIFT && sck_rise
            && clock_count_q < sbc_pkg::BITS_PER_BYTE) begin
            serial_shift_reg_q <= {serial_shift_reg_q[6:0], data_now}; // RQ3
        end
    end
    // ****************************************
    // output latch
    // ****************************************
    // msb out on falling edges; triggers force it when idle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            serial_output_latch_q <= 1'b1;
        end else if (state_q == sbc_pkg::SBC_SHIFT && sck_fall) begin
            // the acknowledge clock releases own bit
            serial_output_latch_q <= clock_count_q < sbc_pkg::BITS_PER_BYTE
                ? serial_shift_reg_q[7] : 1'b1; // RQ1 RQ2
        end else if (wr_bus && channel_enable_bit_q
            && reg_wdata[sbc_pkg::POS_RELEASE_TRIGGER]) begin
            serial_output_latch_q <= 1'b1; // RQ21
        end else if (wr_bus && channel_enable_bit_q
            && reg_wdata[sbc_pkg::POS_COMMAND_TRIGGER]) begin
            serial_output_latch_q <= 1'b0; // RQ23
        end
    end
    // ****************************************
    // acknowledge and busy
    // ****************************************
    // ack low for one clock; busy from the fall after the byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_drive_q <= 1'b0;
            busy_drive_q <= 1'b0;
            after_last_q <= 1'b0;
            ack_detect_q <= 1'b0;
        end else if (!channel_enable_bit_q) begin
            ack_drive_q <= 1'b0;
            busy_drive_q <= 1'b0;
            after_last_q <= 1'b0;
            ack_detect_q <= 1'b0;
        end else begin
            if (wr_bus && reg_wdata[sbc_pkg::POS_ACK_TRIGGER]) begin
                ack_drive_q <= 1'b1;
            end else if (sck_fall) begin
                ack_drive_q <= 1'b0;
            end
            if (byte_done) begin
                after_last_q <= 1'b1;
            end else if (sck_fall) begin
                after_last_q <= 1'b0;
            end
            // busy changes only on a falling edge, so clearing it lags one clock
            if (sck_fall && after_last_q && busy_enable_q) begin
                busy_drive_q <= 1'b1;
            end else if (sck_fall && !busy_enable_q) begin // RQ12
                busy_drive_q <= 1'b0;
            end else if (state_q == sbc_pkg::SBC_WAIT_READY && sck_fall) begin
                busy_drive_q <= 1'b0;
            end
            // line low on the acknowledge clock counts as acknowledge
            if (byte_done && bus_mode && !data_now) begin
                ack_detect_q <= 1'b1;
            end else if (shift_req) begin
                ack_detect_q <= 1'b0;
            end
        end
    end
    // ****************************************
    // release and command detection
    // ****************************************
    // data edges with clock high; new detection beats the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            release_detect_flag_q <= 1'b0;
            command_detect_flag_q <= 1'b0;
        end else if (!channel_enable_bit_q || !bus_mode) begin
            release_detect_flag_q <= 1'b0;
            command_detect_flag_q <= 1'b0;
        end else if (sck_now && sck_prev_q && data_now && !data_prev_q) begin
            release_detect_flag_q <= 1'b1; // RQ24
            command_detect_flag_q <= 1'b0; // RQ24
        end else if (sck_now && sck_prev_q && !data_now && data_prev_q) begin
            command_detect_flag_q <= 1'b1;
        end else if (byte_done) begin
            release_detect_flag_q <= 1'b0; // address byte consumed
        end
    end
    // ****************************************
    // interrupt request
    // ****************************************
    // one pulse per byte, plus one per release detect with release_irq_q in bus mode, or under wake-up in bus mode without release_irq_q only on address match
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channel_interrupt <= 1'b0;
        end else if (!channel_enable_bit_q) begin
            channel_interrupt <= 1'b0;
        end else if (release_irq_q && bus_mode && sck_now && sck_prev_q
            && data_now && !data_prev_q) begin
            channel_interrupt <= 1'b1;
        end else if (byte_done) begin
            if (!wake_up_control_q || !bus_mode || release_irq_q) begin
                channel_interrupt <= 1'b1; // RQ9 RQ18 RQ25
            end else begin
                // no shift at this edge; compare the register shifted once more with the line level now
                channel_interrupt <= release_detect_flag_q && command_detect_flag_q
                    && slave_address_reg_q == {serial_shift_reg_q[6:0], data_now}; // RQ14 RQ18
            end
        end else begin
            channel_interrupt <= 1'b0;
        end
    end
    // ****************************************
    // pin drive
    // ****************************************
    logic data_low; // pull the open-drain line low
    logic active; // a serial mode is in use
    assign active = channel_enable_bit_q && (bus_mode || two_wire_mode);
    // wake-up releases data bits; only busy still pulls low
    assign data_low = active && (busy_drive_q
        || (!wake_up_control_q && (!serial_output_latch_q || ack_drive_q))); // RQ7 RQ2

    always_comb begin
        pins_out.data_a_o = 1'b0;
        pins_out.data_b_o = 1'b0;
        pins_out.data_a_oe_n = !(data_low && use_pin_a);
        pins_out.data_b_oe_n = !(data_low && !use_pin_a);
        pins_out.serial_clock_o = sck_level_q;
        // push-pull in bus mode, open-drain in two-wire mode
        pins_out.serial_clock_oe_n = !(active && internal_clk
            && (bus_mode || !sck_level_q));
    end
    // ****************************************
    // register read
    // ****************************************
    logic address_compare_flag;
    logic clock_level_bit;
    assign address_compare_flag = channel_enable_bit_q
        && slave_address_reg_q == serial_shift_reg_q; // RQ14 RQ20
    assign clock_level_bit = channel_enable_bit_q && sck_now; // RQ22

    // data one cycle after the strobe; no strobe reads as zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_read ? reg_addr : '0)
                sbc_pkg::OFF_SERIAL_MODE_CONTROL:
                    reg_rdata <= {channel_enable_bit_q, address_compare_flag,
                        wake_up_control_q, mode_select_q, clock_select_q};
                sbc_pkg::OFF_BUS_SIGNAL_CONTROL:
                    reg_rdata <= {busy_enable_q, ack_detect_q, ack_enable_q, 1'b0,
                        command_detect_flag_q, release_detect_flag_q, 2'b00};
                sbc_pkg::OFF_INTERRUPT_TIMING:
                    reg_rdata <= {1'b0, clock_level_bit, release_irq_q, 5'h00};
                sbc_pkg::OFF_SERIAL_SHIFT:
                    reg_rdata <= serial_shift_reg_q;
                sbc_pkg::OFF_SLAVE_ADDRESS:
                    reg_rdata <= slave_address_reg_q;
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: bench/sbc_assertions.sv
// sbc_assertions: port checker of the serial channel
`timescale 1ns/1ns
`default_nettype none
module sbc_assertions (
    // clock and register port
    input wire logic clk,
    input wire logic resetn,
    input wire logic [sbc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // ticks, pins, interrupt
    input wire logic timer_two_output,
    input wire logic timer_clock_select,
    input wire sbc_pkg::sbc_pin_in_type pins_in,
    input wire sbc_pkg::sbc_pin_out_type pins_out,
    input wire logic channel_interrupt
);
    logic [7:0] m_q; // mode as last written
    wire wa = reg_write && reg_addr == 16'hff61; // bus control write
    wire rm = reg_read && reg_addr == 16'hff60; // mode read
    wire rt = reg_read && reg_addr == 16'hff62; // timing read
    wire tw = m_q[7] && m_q[4:2] == 3'h6; // enabled two-wire on line b
    // shadow of the mode register, cleared with the block
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) m_q <= 8'h00;
        else if (reg_write && reg_addr == 16'hff60) m_q <= reg_wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_pls; channel_interrupt |=> !channel_interrupt; endproperty
    a_pls: assert property (p_pls) else $error("irq too long");
    property p_off; !m_q[7] |-> !channel_interrupt; endproperty
    a_off: assert property (p_off) else $error("irq while off");
    property p_lna; tw |-> pins_out.data_a_oe_n; endproperty
    a_lna: assert property (p_lna) else $error("wrong line");
    property p_od; !pins_out.data_a_o && !pins_out.data_b_o; endproperty
    a_od: assert property (p_od) else $error("line driven high");
    property p_rel; wa && reg_wdata[0] && tw |-> ##[1:3] pins_out.data_b_oe_n; endproperty
    a_rel: assert property (p_rel) else $error("release kept low");
    property p_cmd; wa && reg_wdata[1:0] == 2'h2 && tw |-> ##[1:3] !pins_out.data_b_oe_n; endproperty
    a_cmd: assert property (p_cmd) else $error("command not low");
    property p_cld; rt && !m_q[7] |=> !reg_rdata[6]; endproperty
    a_cld: assert property (p_cld) else $error("level while off");
    property p_coi; rm && !m_q[7] |=> !reg_rdata[6]; endproperty
    a_coi: assert property (p_coi) else $error("match while off");
    // clock moves only one or two cycles after a select tick
    property p_ck; m_q[7] && m_q[1:0] == 2'h3 && $changed(pins_out.serial_clock_o)
        |-> $past(timer_clock_select) || $past(timer_clock_select, 2); endproperty
    a_ck: assert property (p_ck) else $error("clock without tick");
    c_irq: cover property (channel_interrupt);
    c_cmd: cover property (wa && tw);
    c_rt: cover property (rt && m_q[7]);
endmodule
bind sbc_channel sbc_assertions chk (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .timer_two_output, .timer_clock_select, .pins_in, .pins_out, .channel_interrupt);
`default_nettype wire

// file: bench/sbc_far_end.sv
// sbc_far_end: open-drain bus partner swapping one byte per arm
`timescale 1ns/1ns
`default_nettype none
module sbc_far_end (
    // wire levels
    input wire logic sck,
    input wire logic sda,
    // byte handling
    input wire logic [7:0] tx,
    input wire logic arm,
    output logic drv,
    output logic [7:0] rx
);
    int n; // bits sent
    initial drv = 1'b1; // released until the first arm
    // msb first on falling clock; released once the byte is out
    always @(negedge sck or posedge arm) begin
        if (arm) n = 0;
        else n = n + 1;
        drv = (n > 0 && n < 9) ? tx[8 - n] : 1'b1;
    end
    always @(posedge sck) rx = {rx[6:0], sda}; // sample on rise
endmodule
`default_nettype wire

// file: bench/sbc_channel_bench.sv
// sbc_channel_bench: self-checking bench of the serial channel
`timescale 1ns/1ns
`default_nettype none
module sbc_channel_bench;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, t2 = 1'b0, tc = 1'b0;
    logic arm = 1'b0, drv, chi;
    logic [15:0] ad = 16'h0000;
    logic [7:0] wd = 8'h00, q, ptx, prx, lx, lf = 8'h57;
    int mismatches = 0, checks_done = 0, irqs = 0, cyc = 0, k, e, b;
    sbc_pkg::sbc_pin_out_type po;
    wire sck = po.serial_clock_oe_n | po.serial_clock_o; // pulled up when released
    wire sdb = (po.data_b_oe_n | po.data_b_o) & drv; // wired-and with pull-up
    wire sbc_pkg::sbc_pin_in_type pi = {sck, sdb, po.data_a_oe_n | po.data_a_o};
    sbc_channel DUT (.clk(clk), .resetn(resetn), .reg_addr(ad), .reg_wdata(wd), .reg_write(wr),
        .reg_read(rd), .reg_rdata(q), .timer_two_output(t2), .timer_clock_select(tc),
        .pins_in(pi), .pins_out(po), .channel_interrupt(chi));
    sbc_far_end FAR (.sck(sck), .sda(sdb), .tx(ptx), .arm(arm), .drv(drv), .rx(prx));
    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    always #10 clk = ~clk;
    // tick every 4 cycles: 160 ns serial clock; timer two output follows bit 0 of lf
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tc <= (cyc % 4) == 0;
        t2 <= lf[0];
        if (chi === 1'b1) irqs <= irqs + 1;
    end
    task chk(input logic [7:0] s, x, input string n);
        checks_done++;
        if (s !== x) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, x, s);
        end
    endtask
    task w(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) begin wr <= 1'b1; ad <= a; wd <= d; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task r(input logic [15:0] a, input logic [7:0] x, input string n);
        @(posedge clk) begin rd <= 1'b1; ad <= a; end
        @(posedge clk) rd <= 1'b0;
        #1 chk(q, x, n);
    endtask
    // one byte each way; model: the line is the and of both senders
    task xfer;
        logic [7:0] d;
        d = (b == 0) ? 8'hff : lf;
        ptx = nx(lf);
        lf = nx(ptx);
        lx = d & ptx;
        e = irqs;
        arm = 1'b1;
        #1 arm = 1'b0;
        w(16'hff63, d);
        for (k = 0; k < 400 && irqs == e; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        chk(8'(irqs - e), 8'h01, "irq count");
        chk(prx, lx, "far rx");
        r(16'hff63, lx, "shift rx");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        r(16'hff60, 8'h00, "mode");
        r(16'hff61, 8'h00, "bus ctl");
        r(16'hff62, 8'h00, "timing");
        w(16'hff70, 8'h5a);
        r(16'hff70, 8'h00, "unmapped");
        w(16'hff63, 8'h55);
        w(16'hff60, 8'h9b);
        e = irqs;
        repeat (100) @(posedge clk);
        chk(8'(irqs - e), 8'h00, "late enable");
        r(16'hff63, 8'h00, "shift");
        r(16'hff60, 8'hdb, "mode match");
        w(16'hff61, 8'h02);
        repeat (2) @(posedge clk);
        chk({7'h00, sdb}, 8'h00, "cmd line");
        w(16'hff61, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h00, sdb}, 8'h01, "rel line");
        r(16'hff61, 8'h00, "triggers");
        for (b = 0; b < 3; b++) xfer();
        r(16'hff62, 8'h40, "clock level");
        w(16'hff64, lx);
        r(16'hff60, 8'hdb, "mode match");
        w(16'hff60, 8'h1b);
        r(16'hff62, 8'h00, "level off");
        r(16'hff60, 8'h1b, "match off");
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
